// file: src/tdmta_params.svh
`ifndef TDMTA_PARAMS_SVH
`define TDMTA_PARAMS_SVH
// register byte offsets
`define TDMTA_CTRL_OFS 12'h000
`define TDMTA_OTS_OFS 12'h004
`define TDMTA_IMR_OFS 12'h008
`define TDMTA_STAT_OFS 12'h00c
`define TDMTA_SIC_BASE 12'h100
`define TDMTA_SOC_BASE 12'h200
// control_register fields
`define TDMTA_IN_POL_BIT 7
`define TDMTA_IN_POS_BIT 9
`define TDMTA_CKIN_LSB 5
`define TDMTA_DIV_MODE_BIT 10
// out_timing_select_register fields, four bits per group except the two-bit pair 3 select
`define TDMTA_FP_POL_LSB 0
`define TDMTA_FP_POS_LSB 4
`define TDMTA_CK_POL_LSB 8
`define TDMTA_P3_SEL_LSB 12
// internal_mode_register: [3:0] pulse enables, [7:4] clock enables
`define TDMTA_FP_EN_LSB 0
`define TDMTA_CK_EN_LSB 4
// stream control fields
`define TDMTA_RATE_LSB 0
`define TDMTA_SMP_LSB 4
`define TDMTA_IBD_LSB 6
`define TDMTA_OAD_LSB 4
`define TDMTA_OFA_LSB 7
`define TDMTA_HZA_LSB 9
// reset values
`define TDMTA_CTRL_RST 16'h0000
`define TDMTA_OTS_RST 16'h0000
`define TDMTA_IMR_RST 16'h00ff
`define TDMTA_SIC_RST 16'h0020
`define TDMTA_SOC_RST 16'h0000
// timing: frame period and the time-base unit rate
`define TDMTA_FRAME_NS 125000
`define TDMTA_UNIT_KHZ 65536
`define TDMTA_FRAME_UNITS ((64'd125000 * 64'd65536) / 64'd1000000)
`endif

// file: src/tdmta_pkg.sv
package tdmta_pkg;
   typedef enum logic [1:0] {
      TDMTA_R2M,
      TDMTA_R4M,
      TDMTA_R8M,
      TDMTA_R16M
   } tdmta_rate_t;
   typedef logic [15:0] tdmta_reg_t;
endpackage

// file: src/tdmta_core.sv
`include "tdmta_params.svh"
// Notes on behaviour
// - st-bus: boundary at clock fall, pulse low
// - gci: boundary at clock rise, pulse high
// - reset st-bus; gci input needs both bits
// - output gci needs polarity and position set
// - per-clock polarity bit, default negative-going
// - each frame pulse format set independently
// - four pulses, four clocks, 8 khz frames
// - defaults align all outputs at boundary
// - pairs 0-2 fixed clocks and pulse widths
// - pair 3 rate selectable, width follows
// - disabled pulse or clock output floats
// - divided mode: no clock above input clock
// - input whole-bit delay 0 to 7
// - input sample point quarters, default 3/4
// - 16 mbps sample: 1/2 default, or 4/4
// - output whole-bit advance 0 to 7
// - output fractional advance in quarter bits
// - 16 mbps fraction only 0 or 1/2
// - hiz strobe follows its stream timing
// - hiz strobe extra advance up to 4/4
// - 16 mbps hiz advance 0, 1/2, 1
// - divided mode timed from input timing
module tdmta_core
   import tdmta_pkg::*;
#(
   parameter int NSTR = 16,
   parameter int NHIZ = 8,
   parameter int UNIT_DIV = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic in_frame_pulse_pin,
   input wire logic [NSTR-1:0] in_stream,
   output logic [NSTR*8-1:0] rx_byte,
   output logic [NSTR-1:0] rx_valid,
   input wire logic [NSTR*8-1:0] tx_byte,
   input wire logic [NSTR-1:0] tx_active,
   output logic [NSTR-1:0] tx_load,
   output logic [NSTR-1:0] out_stream,
   output logic [NSTR-1:0] out_stream_oe_n,
   output logic [NHIZ-1:0] ext_hiz_control,
   output logic [3:0] out_clock_pin,
   output logic [3:0] out_clock_pin_oe_n,
   output logic [3:0] out_frame_pulse_pin,
   output logic [3:0] out_frame_pulse_pin_oe_n,
   output logic frame_boundary
);

   // quarter-bit count to time-base units at a given rate
   function automatic logic [12:0] q2u(input logic [1:0] r, input logic [5:0] qt);
      q2u = 13'(qt) << (2'd3 - r);
   endfunction

   function automatic logic [12:0] bmask(input logic [1:0] r);
      bmask = (13'h0020 >> r) - 13'h0001;
   endfunction

   function automatic logic [2:0] bidx(input logic [1:0] r, input logic [12:0] t);
      logic [12:0] s;
      s = t >> (3'd5 - {1'b0, r});
      bidx = s[2:0];
   endfunction

   function automatic logic [15:0] wmerge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] be);
      logic [15:0] m;
      m = {{8{be[1]}}, {8{be[0]}}};
      wmerge = (old & ~m) | (d[15:0] & m);
   endfunction

   tdmta_reg_t ctrl_r, ots_r, imr_r, ots_a;
   tdmta_reg_t sic_r [NSTR];
   tdmta_reg_t soc_r [NSTR];
   tdmta_reg_t sic_a [NSTR];
   tdmta_reg_t soc_a [NSTR];
   logic [31:0] prdata_r;
   logic [7:0] div_r;
   logic [12:0] pos_r;
   logic fp_in_d_r;
   logic unit_en, wrap, resync, in_act, gci_in;
   logic acc, wr, hit;
   logic [3:0] ck_nxt, fp_nxt;

   // ---------------- apb slave ----------------
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign pready = 1'b1;
   assign prdata = prdata_r;

   always_comb begin
      hit = (paddr == `TDMTA_CTRL_OFS) || (paddr == `TDMTA_OTS_OFS) ||
            (paddr == `TDMTA_IMR_OFS) || (paddr == `TDMTA_STAT_OFS);
      for (int k = 0; k < NSTR; k++) begin
         if (paddr == `TDMTA_SIC_BASE + 12'(4 * k)) begin
            hit = 1'b1;
         end
         if (paddr == `TDMTA_SOC_BASE + 12'(4 * k)) begin
            hit = 1'b1;
         end
      end
   end

   // an unmapped access still completes; the error only flags it
   assign pslverr = acc & ~hit;

   // read data is prepared in the setup cycle so access ends in one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= 32'h0000_0000;
         if (paddr == `TDMTA_CTRL_OFS) prdata_r <= {16'h0000, ctrl_r};
         if (paddr == `TDMTA_OTS_OFS) prdata_r <= {16'h0000, ots_r};
         if (paddr == `TDMTA_IMR_OFS) prdata_r <= {16'h0000, imr_r};
         if (paddr == `TDMTA_STAT_OFS) prdata_r <= {19'h0_0000, pos_r};
         for (int k = 0; k < NSTR; k++) begin
            if (paddr == `TDMTA_SIC_BASE + 12'(4 * k)) prdata_r <= {16'h0000, sic_r[k]};
            if (paddr == `TDMTA_SOC_BASE + 12'(4 * k)) prdata_r <= {16'h0000, soc_r[k]};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `TDMTA_CTRL_RST;
         ots_r <= `TDMTA_OTS_RST;
         imr_r <= `TDMTA_IMR_RST;
         for (int k = 0; k < NSTR; k++) begin
            sic_r[k] <= `TDMTA_SIC_RST;
            soc_r[k] <= `TDMTA_SOC_RST;
         end
      end else if (wr) begin
         if (paddr == `TDMTA_CTRL_OFS) ctrl_r <= wmerge(ctrl_r, pwdata, pstrb);
         if (paddr == `TDMTA_OTS_OFS) ots_r <= wmerge(ots_r, pwdata, pstrb);
         if (paddr == `TDMTA_IMR_OFS) imr_r <= wmerge(imr_r, pwdata, pstrb);
         for (int k = 0; k < NSTR; k++) begin
            if (paddr == `TDMTA_SIC_BASE + 12'(4 * k)) begin
               sic_r[k] <= wmerge(sic_r[k], pwdata, pstrb);
            end
            if (paddr == `TDMTA_SOC_BASE + 12'(4 * k)) begin
               soc_r[k] <= wmerge(soc_r[k], pwdata, pstrb);
            end
         end
      end
   end

   // ---------------- time base ----------------
   // one unit per UNIT_DIV cycles; every rate is a power-of-two multiple
   assign unit_en = (div_r == 8'(UNIT_DIV - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 8'h00;
      end else if (unit_en) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end

   assign gci_in = ctrl_r[`TDMTA_IN_POS_BIT] & ctrl_r[`TDMTA_IN_POL_BIT];
   assign in_act = gci_in ? in_frame_pulse_pin : ~in_frame_pulse_pin;
   // the trailing edge of the input pulse marks the boundary, so a pulse
   // arriving early restarts the frame at once instead of waiting for a wrap
   assign resync = fp_in_d_r & ~in_act;
   assign wrap = unit_en && (pos_r == 13'(`TDMTA_FRAME_UNITS - 64'd1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fp_in_d_r <= 1'b0;
      end else begin
         fp_in_d_r <= in_act;
      end
   end

   // frame position follows the input frame pulse, so output timing
   // carries exactly the input timing's jitter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_r <= 13'h0000;
      end else if (resync) begin
         pos_r <= 13'h0000;
      end else if (unit_en) begin
         pos_r <= pos_r + 13'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_boundary <= 1'b0;
      end else begin
         frame_boundary <= wrap | resync;
      end
   end

   // active copies change only at a boundary, never mid-frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ots_a <= `TDMTA_OTS_RST;
         for (int k = 0; k < NSTR; k++) begin
            sic_a[k] <= `TDMTA_SIC_RST;
            soc_a[k] <= `TDMTA_SOC_RST;
         end
      end else if (wrap || resync) begin
         ots_a <= ots_r;
         for (int k = 0; k < NSTR; k++) begin
            sic_a[k] <= sic_r[k];
            soc_a[k] <= soc_r[k];
         end
      end
   end

   // ---------------- output clocks and frame pulses ----------------
   generate
      for (genvar n = 0; n < 4; n++) begin : g_pair
         logic [1:0] rk;
         logic [1:0] in_k;
         logic [12:0] half;
         logic win, inval, gci_o;
         // pair 3 rate is software selected, the rest are fixed
         assign rk = (n == 3) ? ots_a[`TDMTA_P3_SEL_LSB +: 2] : 2'(n);
         assign half = 13'h0008 >> rk;
         assign in_k = (ctrl_r[`TDMTA_CKIN_LSB +: 2] == 2'b00) ? 2'd2 :
                       (ctrl_r[`TDMTA_CKIN_LSB +: 2] == 2'b01) ? 2'd1 : 2'd0;
         // an out-of-range pair parks its clock low and its pulse inactive
         // rather than running at a rate the input clock cannot support
         assign inval = ctrl_r[`TDMTA_DIV_MODE_BIT] && (rk > in_k);
         assign gci_o = ots_a[`TDMTA_FP_POL_LSB + n] & ots_a[`TDMTA_FP_POS_LSB + n];
         // st-bus pulse straddles the boundary; gci pulse follows it
         assign win = gci_o ? (pos_r < (half << 1)) :
                      ((pos_r < half) || (pos_r >= 13'h0000 - half));
         always_comb begin
            ck_nxt[n] = pos_r[2'd3 - rk] ^ ots_a[`TDMTA_CK_POL_LSB + n];
            fp_nxt[n] = gci_o ? win : ~win;
            if (inval) begin
               ck_nxt[n] = 1'b0;
               fp_nxt[n] = ~gci_o;
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_clock_pin <= 4'h0;
         out_frame_pulse_pin <= 4'hf;
      end else begin
         out_clock_pin <= ck_nxt;
         out_frame_pulse_pin <= fp_nxt;
      end
   end

   // enables act at once: a floated pin needs no frame alignment
   assign out_frame_pulse_pin_oe_n = ~imr_r[`TDMTA_FP_EN_LSB +: 4];
   assign out_clock_pin_oe_n = ~imr_r[`TDMTA_CK_EN_LSB +: 4];

   // ---------------- per-stream input alignment ----------------
   generate
      for (genvar i = 0; i < NSTR; i++) begin : g_in
         logic [1:0] r, sc;
         logic [2:0] d;
         logic [5:0] s;
         logic [12:0] y;
         logic samp;
         logic [6:0] sh_r;
         assign r = sic_a[i][`TDMTA_RATE_LSB +: 2];
         assign sc = sic_a[i][`TDMTA_SMP_LSB +: 2];
         assign d = sic_a[i][`TDMTA_IBD_LSB +: 3];
         // at 16 mbps only the half and full bit sample points exist
         assign s = (r == TDMTA_R16M) ? ((sc == 2'b11) ? 6'd4 : 6'd2)
                                      : 6'({1'b0, sc} + 3'd1);
         // the whole-bit delay keeps the sample grid and only moves the bit index
         assign y = pos_r - q2u(r, {1'b0, d, 2'b00} + s);
         assign samp = unit_en && ((y & bmask(r)) == 13'h0000);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sh_r <= 7'h00;
               rx_byte[i*8 +: 8] <= 8'h00;
               rx_valid[i] <= 1'b0;
            end else begin
               rx_valid[i] <= 1'b0;
               if (samp) begin
                  sh_r <= {sh_r[5:0], in_stream[i]};
                  if (bidx(r, y) == 3'd7) begin
                     rx_byte[i*8 +: 8] <= {sh_r, in_stream[i]};
                     rx_valid[i] <= 1'b1;
                  end
               end
            end
         end
      end
   endgenerate

   // ---------------- per-stream output advancement ----------------
   generate
      for (genvar i = 0; i < NSTR; i++) begin : g_out
         logic [1:0] r, fc;
         logic [2:0] ad, hc;
         logic [5:0] f, h;
         logic [12:0] z, zh;
         logic bst, hst;
         logic [7:0] byte_r;
         logic act_r;
         assign r = soc_a[i][`TDMTA_RATE_LSB +: 2];
         assign ad = soc_a[i][`TDMTA_OAD_LSB +: 3];
         assign fc = soc_a[i][`TDMTA_OFA_LSB +: 2];
         assign hc = soc_a[i][`TDMTA_HZA_LSB +: 3];
         assign f = (r == TDMTA_R16M) ? {4'h0, fc[1], 1'b0} : {4'h0, fc};
         // advancing the data means looking ahead in frame position
         assign z = pos_r + q2u(r, {1'b0, ad, 2'b00} + f);
         assign bst = unit_en && ((z & bmask(r)) == 13'h0000);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               byte_r <= 8'h00;
               act_r <= 1'b0;
               tx_load[i] <= 1'b0;
               out_stream[i] <= 1'b1;
            end else begin
               tx_load[i] <= 1'b0;
               if (bst) begin
                  if (bidx(r, z) == 3'd0) begin
                     // channel start: bit 7 leaves first
                     byte_r <= tx_byte[i*8 +: 8];
                     act_r <= tx_active[i];
                     tx_load[i] <= 1'b1;
                     out_stream[i] <= tx_byte[i*8 + 7];
                  end else begin
                     out_stream[i] <= byte_r[3'd7 - bidx(r, z)];
                  end
               end
            end
         end
         // the bus drivers themselves are off in idle channels
         assign out_stream_oe_n[i] = ~act_r;
         if (i < NHIZ) begin : g_hz
            logic hz_r;
            // values above a full bit clamp to a full bit
            assign h = (hc > 3'd4) ? 6'd4 :
                       (r == TDMTA_R16M) ? {3'h0, hc[2:1], 1'b0} : {3'h0, hc};
            // the strobe leads its data by the extra advance, on top of the data's own
            assign zh = z + q2u(r, h);
            assign hst = unit_en && ((zh & bmask(r)) == 13'h0000);
            always_ff @(posedge pclk or negedge presetn) begin
               if (!presetn) begin
                  hz_r <= 1'b1;
               end else if (hst && (bidx(r, zh) == 3'd0)) begin
                  hz_r <= ~tx_active[i];
               end
            end
            assign ext_hiz_control[i] = hz_r;
         end else begin : g_nohz
            assign h = 6'h00;
            assign zh = z;
            assign hst = 1'b0;
         end
      end
   endgenerate

endmodule

// file: verif/tdmta_peer.sv
module tdmta_peer #(
   parameter int P = 8192
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic act,
   output logic fp_n,
   output logic [15:0] sd,
   output logic [127:0] txb,
   output logic [15:0] txa
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] PAT = 8'ha5;
   int cnt;
   // start mid-frame so the first resync never lands on an internal wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= P / 2;
      end else begin
         cnt <= (cnt == P - 1) ? 0 : cnt + 1;
      end
   end
   assign fp_n = (cnt < P - 4);
   // 2.048 Mbps: 32 cycles a bit, msb first, same byte in every channel
   assign sd = {16{PAT[3'(7 - (cnt / 32) % 8)]}};
   assign txb = {16{8'h3c}};
   assign txa = {16{act}};
endmodule

// file: verif/tdmta_core_props.sv
module tdmta_core_props #(
   parameter int UNIT_DIV = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] out_clock_pin,
   input wire logic [3:0] out_frame_pulse_pin,
   input wire logic frame_boundary
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int FC = 8192 * UNIT_DIV;
   int fcnt;
   int nb;
   int cr [3];
   int fr [3];
   logic [3:0] cq;
   logic [3:0] fq;
   // the first resync may cut a run short, so checks wait for two boundaries
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fcnt <= 0;
         nb <= 0;
         cq <= 4'h0;
         fq <= 4'hf;
         cr <= '{0, 0, 0};
         fr <= '{0, 0, 0};
      end else begin
         fcnt <= frame_boundary ? 0 : fcnt + 1;
         if (frame_boundary && nb < 2) begin
            nb <= nb + 1;
         end
         cq <= out_clock_pin;
         fq <= out_frame_pulse_pin;
         for (int k = 0; k < 3; k++) begin
            cr[k] <= (out_clock_pin[k] != cq[k]) ? 1 : cr[k] + 1;
            fr[k] <= (out_frame_pulse_pin[k] != fq[k]) ? 1 : fr[k] + 1;
         end
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_unmapped_err: assert property (psel && penable && paddr >= 12'h010 && paddr < 12'h100
      |-> pslverr) else $error("no error on unmapped address");
   a_frame_period: assert property (frame_boundary && nb == 2 |-> fcnt == FC - 1)
      else $error("frame period wrong");
   a_st_boundary: assert property ($fell(out_clock_pin[0]) && !out_frame_pulse_pin[0]
      && nb == 2 |-> fcnt < 4 || fcnt > FC - 5) else $error("boundary edge misplaced");
   a_ck0_half: assert property (nb == 2 && out_clock_pin[0] != cq[0]
      |-> cr[0] == 8 * UNIT_DIV) else $error("clock 0 half period wrong");
   a_ck1_half: assert property (nb == 2 && out_clock_pin[1] != cq[1]
      |-> cr[1] == 4 * UNIT_DIV) else $error("clock 1 half period wrong");
   a_ck2_half: assert property (nb == 2 && out_clock_pin[2] != cq[2]
      |-> cr[2] == 2 * UNIT_DIV) else $error("clock 2 half period wrong");
   a_fp0_width: assert property (nb == 2 && out_frame_pulse_pin[0] && !fq[0]
      |-> fr[0] == 16 * UNIT_DIV) else $error("pulse 0 width wrong");
   a_fp2_width: assert property (nb == 2 && out_frame_pulse_pin[2] && !fq[2]
      |-> fr[2] == 4 * UNIT_DIV) else $error("pulse 2 width wrong");
endmodule
bind tdmta_core tdmta_core_props #(.UNIT_DIV(UNIT_DIV)) props_u (.pclk(pclk),
   .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .out_clock_pin(out_clock_pin), .out_frame_pulse_pin(out_frame_pulse_pin),
   .frame_boundary(frame_boundary));

// file: verif/tb_tdm_output_timing_and_bit_alignment.sv
`include "tdmta_params.svh"
module tb_tdm_output_timing_and_bit_alignment
   import tdmta_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, act, fp_n, fb;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb, ck, ck_oe_n, fp, fp_oe_n;
   logic [15:0] sd, txa, txl, os, os_oe_n, rxv;
   logic [127:0] txb, rxb;
   logic [7:0] hiz;
   int bad_count = 0;
   int n_tests = 0;
   tdmta_core #(.NSTR(16), .NHIZ(8), .UNIT_DIV(1)) dut_u (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .in_frame_pulse_pin(fp_n), .in_stream(sd), .rx_byte(rxb),
      .rx_valid(rxv), .tx_byte(txb), .tx_active(txa), .tx_load(txl), .out_stream(os),
      .out_stream_oe_n(os_oe_n), .ext_hiz_control(hiz), .out_clock_pin(ck),
      .out_clock_pin_oe_n(ck_oe_n), .out_frame_pulse_pin(fp),
      .out_frame_pulse_pin_oe_n(fp_oe_n), .frame_boundary(fb));
   tdmta_peer peer_u (.pclk(pclk), .presetn(presetn), .act(act), .fp_n(fp_n), .sd(sd),
      .txb(txb), .txa(txa));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(a, 1'b1, d, q, e);
      @(posedge pclk);
   endtask
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] ex,
      input logic ee);
      logic [31:0] q;
      logic e;
      apb(a, 1'b0, 32'h0000_0000, q, e);
      chk(nm, ex, q);
      chk({nm, " slverr"}, {31'h0, ee}, {31'h0, e});
   endtask
   task automatic wfb(input int n);
      repeat (n) begin
         @(posedge pclk);
         while (fb !== 1'b1) @(posedge pclk);
      end
   endtask
   // sample mid-bit, 2.048 Mbps is 32 cycles a bit
   task automatic obyte(input logic [7:0] ex, input string nm);
      logic [7:0] v;
      wfb(1);
      repeat (16) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         v = {v[6:0], os[0]};
         repeat (32) @(posedge pclk);
      end
      chk(nm, {24'h0, ex}, {24'h0, v});
   endtask
   task automatic rxchk(input logic [7:0] ex);
      @(posedge pclk);
      while (rxv[0] !== 1'b1) @(posedge pclk);
      chk("rx byte", {24'h0, ex}, {24'h0, rxb[7:0]});
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      int t, u;
      logic [3:0] p3;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'hf;
      act = 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd("ctrl", `TDMTA_CTRL_OFS, 32'h0000_0000, 1'b0);
      rd("ots", `TDMTA_OTS_OFS, 32'h0000_0000, 1'b0);
      rd("imr", `TDMTA_IMR_OFS, 32'h0000_00ff, 1'b0);
      rd("sic0", `TDMTA_SIC_BASE, 32'h0000_0020, 1'b0);
      rd("soc0", `TDMTA_SOC_BASE, 32'h0000_0000, 1'b0);
      rd("unmapped", 12'h0f0, 32'h0000_0000, 1'b1);
      $display("test registers done");
      wfb(2);
      rxchk(8'ha5);
      obyte(8'h3c, "tx byte");
      // one load pulse per 2.048 Mbps channel, 256 cycles apart
      @(posedge pclk);
      while (txl[0] !== 1'b1) @(posedge pclk);
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (txl[0] !== 1'b1 && t < 1000);
      chk("load spacing", 32'd256, 32'(t));
      chk("hiz on", 32'h0, {31'h0, hiz[0]});
      chk("stream oe", 32'h0, {31'h0, os_oe_n[0]});
      $display("test default alignment done");
      // stream 0 is not bidirectional, so shifting it cannot contend
      wr(`TDMTA_SIC_BASE, 32'h0000_00e0);
      // two whole bits plus three quarters of advance
      wr(`TDMTA_SOC_BASE, 32'h0000_01a0);
      wfb(1);
      repeat (300) @(posedge pclk);
      rxchk(8'h2d);
      obyte(8'he1, "advanced tx byte");
      $display("test delay and advance done");
      act <= 1'b0;
      wfb(1);
      repeat (100) @(posedge pclk);
      chk("hiz off", 32'h1, {31'h0, hiz[0]});
      chk("stream off", 32'h1, {31'h0, os_oe_n[0]});
      act <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         wr(`TDMTA_OTS_OFS, 32'h0000_0022 | 32'(s << 12));
         wfb(1);
         repeat (3) @(posedge pclk);
         chk("gci pulse", 32'h1, {31'h0, fp[1]});
         chk("st pulse", 32'h0, {31'h0, fp[0]});
         t = 0;
         p3 = ck;
         repeat (64) begin
            @(posedge pclk);
            if (ck[3] !== p3[3]) begin
               t++;
            end
            p3 = ck;
         end
         chk("pair 3 toggles", 32'(8 << s), 32'(t));
      end
      $display("test output formats done");
      wr(`TDMTA_IMR_OFS, 32'h0000_005a);
      chk("pin enables", 32'h0000_00a5, {24'h0, ck_oe_n, fp_oe_n});
      wr(`TDMTA_IMR_OFS, 32'h0000_00ff);
      chk("pins driven", 32'h0000_0000, {24'h0, ck_oe_n, fp_oe_n});
      $display("test pin enables done");
      // divided mode from a 16.384 MHz input: pair 3 at 32.768 is out of range
      wr(`TDMTA_CTRL_OFS, 32'h0000_0400);
      repeat (2) @(posedge pclk);
      t = 0;
      u = 0;
      p3 = ck;
      repeat (32) begin
         @(posedge pclk);
         if (ck[3] !== p3[3]) begin
            t++;
         end
         if (ck[2] !== p3[2]) begin
            u++;
         end
         p3 = ck;
      end
      chk("pair 3 parked", 32'h0, 32'(t));
      chk("pair 2 runs", 32'd16, 32'(u));
      chk("pair 3 pulse idle", 32'h1, {31'h0, fp[3]});
      $display("test divided mode done");
      close_out();
   end
   // ten frames of 8192 cycles plus margin
   initial begin
      repeat (100000) @(posedge pclk);
      bad_count++;
      $display("[ERR] watchdog expected done seen hang");
      close_out();
   end
endmodule
